// ===== rtl/external_wakeup_soft_interrupts.v
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "ext_wake_regs.vh"

module external_wakeup_soft_interrupts (
  input wire mclk, // machine clock, always running
  input wire rst_n, // asynchronous reset, active low
  input wire wbCyc, // wishbone cycle
  input wire wbStb, // wishbone strobe
  input wire wbWe, // wishbone write enable
  input wire [7:0] wbAdr, // wishbone byte address
  input wire [3:0] wbSel, // wishbone byte selects
  input wire [31:0] wbDatIn, // wishbone write data
  output reg [31:0] wbDatOut, // wishbone read data
  output reg wbAck, // wishbone acknowledge
  input wire [7:0] extRequestPins, // external request pins
  input wire [7:0] wakePins_n, // wake pins, active low
  input wire hwStandbyPin_n, // hardware standby pin, active low
  input wire swStandby, // cpu is in a software standby mode
  output reg [7:0] extIrq, // handler request per channel
  output reg pinTransferRequest, // request to the intelligent io service
  output reg [2:0] pinTransferChan, // channel being transferred
  input wire transferDone, // one-cycle pulse, transfer finished
  output reg wakeIrq, // wake interrupt to the cpu
  output reg wakeupReq, // leave software standby
  output reg delayedIrq // task switching request
);

  // one-hot states of the transfer sequencer
  // hand is a one-cycle pause after a finished transfer
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_XFER = 3'b010;
  localparam [2:0] ST_HAND = 3'b100;

  // software visible registers
  reg [15:0] detectLevelCfg_r; // two bits per channel
  reg [7:0] extRequestEnable_r; // channel enables
  reg [7:0] extRequestFlags_r; // latched requests
  reg [7:0] extRequestFlags_nxt;
  reg [7:0] autoTransferSelect_r; // per-channel transfer select
  reg [8:0] wakeControl_r; // pin enables plus forwarding enable
  reg wakeFlag_r; // shared wake flag
  reg wakeFlag_nxt;
  reg delayedRequestBit_r; // software interrupt bit
  // sequencer bookkeeping
  reg [7:0] doneSeen_r; // transfer finished for this request
  reg [7:0] doneSeen_nxt;
  reg [2:0] state_r; // sequencer state
  reg [2:0] state_nxt;
  reg [2:0] chan_r; // channel held by the sequencer
  reg [2:0] chan_nxt;
  // combinational helpers, never stored
  reg setDone; // transfer of chan_r finished this cycle
  reg [31:0] readMux; // read data being selected

  // pin side nets
  wire [`SYNC_WIDTH-1:0] pinSync; // synchronised pins
  wire [7:0] extSync; // synchronised request pins
  wire [7:0] wakeSync_n; // synchronised wake pins
  wire hwStandbySync_n; // synchronised hardware standby
  wire [7:0] detectHit; // condition seen per channel
  wire [7:0] transferPend; // channels waiting for a transfer
  wire [7:0] wakeLow; // enabled wake pins held low
  // bus side nets
  wire busAccess; // a request is being acknowledged
  wire busWrite; // write takes effect this edge
  wire [7:0] regAdr; // word aligned address

  // all pins pass two flops before any logic reads them
  // the pins are asynchronous to mclk, so a raw level could go metastable
  // the price is two cycles of latency on every pin event
  pin_sync i_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn({hwStandbyPin_n, wakePins_n, extRequestPins}),
    .rstLevel({`SYNC_WIDTH{1'b1}}),
    .pinSync(pinSync)
  );

  // the bus order is request pins, wake pins, then the standby pin
  assign extSync = pinSync[7:0];
  assign wakeSync_n = pinSync[15:8];
  assign hwStandbySync_n = pinSync[16];

  // one detector per channel, each with its own setting
  // a channel in transfer mode is told so, so it can refuse edge codes
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_EXT_CH; gi = gi + 1) begin : gDet
      ext_channel_detect i_ext_channel_detect (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinLevel(extSync[gi]),
        .detMode(detectLevelCfg_r[2*gi+1:2*gi]),
        .xferMode(autoTransferSelect_r[gi]),
        .hit(detectHit[gi])
      );
    end
  endgenerate

  // merge one byte lane of write data into a stored value
  function [7:0] laneMerge;
    input [7:0] oldVal;
    input [7:0] newVal;
    input laneSel;
    begin
      laneMerge = laneSel ? newVal : oldVal;
    end
  endfunction

  // lane-0 write strobe for one register word, shared by the write-clear flags
  function laneZeroWrite;
    input wr;
    input [7:0] adr;
    input [7:0] ofs;
    input sel0;
    begin
      laneZeroWrite = wr & (adr == ofs) & sel0;
    end
  endfunction

  // lowest numbered set bit, used to pick the next transfer
  // scanning downwards lets the last hit, the lowest index, win
  function [2:0] lowestSet;
    input [7:0] vec;
    integer k;
    begin
      lowestSet = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (vec[k]) begin
          lowestSet = k[2:0];
        end
      end
    end
  endfunction

  // classic wishbone: ack one cycle after the strobe, writes land on the ack edge
  // every access costs two cycles; the master must drop the strobe in between
  // bits 1:0 of the address are ignored, all registers are word wide
  assign busAccess = wbCyc & wbStb & ~wbAck;
  assign busWrite = wbCyc & wbStb & wbWe & wbAck;
  assign regAdr = {wbAdr[7:2], 2'h0};

  // read data selection, unmapped words read zero
  // a plain priority chain; the offsets never overlap so the order is free
  always @* begin
    readMux = 32'h0000_0000;
    if (regAdr == `OFS_DETECT_LEVEL_CFG) begin
      readMux = {16'h0000, detectLevelCfg_r};
    end else if (regAdr == `OFS_EXT_REQUEST_ENABLE) begin
      readMux = {24'h000000, extRequestEnable_r};
    end else if (regAdr == `OFS_EXT_REQUEST_FLAGS) begin
      readMux = {24'h000000, extRequestFlags_r};
    end else if (regAdr == `OFS_IRQ_LEVEL_CONTROL) begin
      readMux = {24'h000000, autoTransferSelect_r};
    end else if (regAdr == `OFS_WAKE_CONTROL) begin
      readMux = {23'h000000, wakeControl_r};
    end else if (regAdr == `OFS_WAKE_FLAG_REG) begin
      readMux = {31'h00000000, wakeFlag_r};
    end else if (regAdr == `OFS_DELAYED_REQUEST_REG) begin
      readMux = {31'h00000000, delayedRequestBit_r};
    end else if (regAdr == `OFS_XFER_STATUS) begin
      readMux = {25'h0000000, chan_r, 3'h0, state_r[1]};
    end
  end

  // bus handshake and read register
  // read data is captured on the accepting edge and held until the next access
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= busAccess;
      if (busAccess) begin
        wbDatOut <= readMux;
      end
    end
  end

  // plain configuration registers
  // only byte lane 0 matters, except the high cfg byte and the wake forward bit
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      detectLevelCfg_r <= `RST_DETECT_LEVEL_CFG;
      extRequestEnable_r <= `RST_EXT_REQUEST_ENABLE;
      autoTransferSelect_r <= `RST_IRQ_LEVEL_CONTROL;
      wakeControl_r <= `RST_WAKE_CONTROL;
      delayedRequestBit_r <= 1'b0;
    end else if (busWrite) begin
      if (regAdr == `OFS_DETECT_LEVEL_CFG) begin
        detectLevelCfg_r[7:0] <= laneMerge(detectLevelCfg_r[7:0], wbDatIn[7:0], wbSel[0]);
        detectLevelCfg_r[15:8] <= laneMerge(detectLevelCfg_r[15:8], wbDatIn[15:8], wbSel[1]);
      end else if (regAdr == `OFS_EXT_REQUEST_ENABLE) begin
        extRequestEnable_r <= laneMerge(extRequestEnable_r, wbDatIn[7:0], wbSel[0]);
      end else if (regAdr == `OFS_IRQ_LEVEL_CONTROL) begin
        autoTransferSelect_r <= laneMerge(autoTransferSelect_r, wbDatIn[7:0], wbSel[0]);
      end else if (regAdr == `OFS_WAKE_CONTROL) begin
        wakeControl_r[7:0] <= laneMerge(wakeControl_r[7:0], wbDatIn[7:0], wbSel[0]);
        if (wbSel[1]) begin
          wakeControl_r[`WAKE_FWD_EN_BIT] <= wbDatIn[`WAKE_FWD_EN_BIT];
        end
      end else if (regAdr == `OFS_DELAYED_REQUEST_REG) begin
        if (wbSel[0]) begin
          // one sets, zero clears; no other state touches this bit
          delayedRequestBit_r <= wbDatIn[`DELAYED_REQUEST_BIT];
        end
      end
    end
  end

  // request flags: writing zero clears a bit, a new hit in the same cycle wins
  always @* begin
    // hold by default
    extRequestFlags_nxt = extRequestFlags_r;
    // ones in the write data keep a flag, so a read-modify-write loses no event
    if (laneZeroWrite(busWrite, regAdr, `OFS_EXT_REQUEST_FLAGS, wbSel[0])) begin
      extRequestFlags_nxt = extRequestFlags_r & wbDatIn[7:0];
    end
    // edge hits stay latched; level hits simply set again while held
    extRequestFlags_nxt = extRequestFlags_nxt | detectHit;
  end

  // wake flag: any enabled pin held low sets the one shared flag
  assign wakeLow = ~wakeSync_n & wakeControl_r[7:0];
  always @* begin
    // hold by default
    wakeFlag_nxt = wakeFlag_r;
    // a pin still held low wins over the clear, so the flag stays set in that cycle
    if (laneZeroWrite(busWrite, regAdr, `OFS_WAKE_FLAG_REG, wbSel[0])) begin
      wakeFlag_nxt = wakeFlag_r & wbDatIn[`WAKE_FLAG_BIT];
    end
    wakeFlag_nxt = wakeFlag_nxt | (|wakeLow);
  end

  // transfer sequencer: one channel at a time, lowest number first
  // a fixed priority is simple, but a busy low channel can starve higher ones
  // pending means flagged, enabled, selected and not yet served
  assign transferPend = extRequestFlags_r & extRequestEnable_r & autoTransferSelect_r &
                        ~doneSeen_r;
  always @* begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    setDone = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // nothing owed: pick the lowest pending channel
        if (|transferPend) begin
          chan_nxt = lowestSet(transferPend);
          state_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        // the service owns the channel until it reports or the request goes away
        if (transferDone) begin
          setDone = 1'b1;
          state_nxt = ST_HAND;
        end else if (!transferPend[chan_r]) begin
          // request withdrawn by software; the service is told by the dropped request
          state_nxt = ST_IDLE;
        end
      end
      ST_HAND: begin
        // one cycle gap so the handler request settles before the next pick
        state_nxt = ST_IDLE;
      end
      default: begin
        // an illegal code falls back to idle rather than locking up
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // finished marks follow their flag: a cleared flag forgets its transfer
  // without the mask a cleared and raised again request would skip its transfer
  always @* begin
    doneSeen_nxt = doneSeen_r;
    if (setDone) begin
      doneSeen_nxt[chan_r] = 1'b1;
    end
    doneSeen_nxt = doneSeen_nxt & extRequestFlags_nxt;
  end

  // state and flag registers
  // the flags live next to the sequencer so both move on one edge
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      extRequestFlags_r <= 8'h00;
      wakeFlag_r <= 1'b0;
      doneSeen_r <= 8'h00;
      state_r <= ST_IDLE;
      chan_r <= 3'h0;
    end else begin
      extRequestFlags_r <= extRequestFlags_nxt;
      wakeFlag_r <= wakeFlag_nxt;
      doneSeen_r <= doneSeen_nxt;
      state_r <= state_nxt;
      chan_r <= chan_nxt;
    end
  end

  // registered outputs toward the cpu and the transfer service
  // every output is a flop, so cpu side timing never sees the decode logic
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      extIrq <= 8'h00;
      pinTransferRequest <= 1'b0;
      pinTransferChan <= 3'h0;
      wakeIrq <= 1'b0;
      wakeupReq <= 1'b0;
      delayedIrq <= 1'b0;
    end else begin
      // direct channels go straight to the handler, others after their transfer
      extIrq <= extRequestFlags_r & extRequestEnable_r &
                (~autoTransferSelect_r | doneSeen_r);
      pinTransferRequest <= (state_nxt == ST_XFER);
      pinTransferChan <= chan_nxt;
      // the forward enable gates only the cpu side; the flag still records the wake
      wakeIrq <= wakeFlag_r & wakeControl_r[`WAKE_FWD_EN_BIT];
      // mclk keeps running in standby, so the flag is caught with the cpu stopped
      wakeupReq <= wakeFlag_r & wakeControl_r[`WAKE_FWD_EN_BIT] & swStandby &
                   hwStandbySync_n;
      // no enable stands in the way: the bit alone raises the request
      delayedIrq <= delayedRequestBit_r;
    end
  end

endmodule // external_wakeup_soft_interrupts

// ===== rtl/ext_wake_regs.vh
`ifndef EXT_WAKE_REGS_VH
`define EXT_WAKE_REGS_VH

// register byte offsets on the wishbone slave
`define OFS_DETECT_LEVEL_CFG 8'h00
`define OFS_EXT_REQUEST_ENABLE 8'h04
`define OFS_EXT_REQUEST_FLAGS 8'h08
`define OFS_IRQ_LEVEL_CONTROL 8'h0c
`define OFS_WAKE_CONTROL 8'h10
`define OFS_WAKE_FLAG_REG 8'h14
`define OFS_DELAYED_REQUEST_REG 8'h18
`define OFS_XFER_STATUS 8'h1c

// channel counts and synchroniser width
`define NUM_EXT_CH 8
`define NUM_WAKE_CH 8
`define SYNC_WIDTH 17

// detection codes, two bits per channel
`define DET_LOW 2'h0
`define DET_HIGH 2'h1
`define DET_RISE 2'h2
`define DET_FALL 2'h3

// field positions
`define WAKE_FWD_EN_BIT 8
`define WAKE_FLAG_BIT 0
`define DELAYED_REQUEST_BIT 0
`define XFER_BUSY_BIT 0
`define XFER_CHAN_LSB 4

// reset values
`define RST_DETECT_LEVEL_CFG 16'h0000
`define RST_EXT_REQUEST_ENABLE 8'h00
`define RST_IRQ_LEVEL_CONTROL 8'h00
`define RST_WAKE_CONTROL 9'h000

`endif

// ===== rtl/pin_sync.v
`timescale 1ns/100ps
`include "ext_wake_regs.vh"

// two-stage synchroniser for every pin that enters from outside mclk
module pin_sync (
  input wire mclk, // machine clock
  input wire rst_n, // asynchronous reset, active low
  input wire [`SYNC_WIDTH-1:0] pinIn, // raw pin levels
  input wire [`SYNC_WIDTH-1:0] rstLevel, // constant level the stages reset to
  output wire [`SYNC_WIDTH-1:0] pinSync // levels safe to use in mclk logic
);

  reg [`SYNC_WIDTH-1:0] meta_r; // first stage, read only by the second
  reg [`SYNC_WIDTH-1:0] sync_r; // second stage

  // reset values come from a tied constant so idle pins do not fire
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {`SYNC_WIDTH{1'b1}};
      sync_r <= {`SYNC_WIDTH{1'b1}};
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
    end
  end

  // rstLevel only masks nothing here; the inactive level of all pins is high
  assign pinSync = sync_r | (rstLevel & ~rstLevel);

endmodule // pin_sync

// ===== rtl/ext_channel_detect.v
`timescale 1ns/100ps
`include "ext_wake_regs.vh"

// condition detector for one external request channel
module ext_channel_detect (
  input wire mclk, // machine clock
  input wire rst_n, // asynchronous reset, active low
  input wire pinLevel, // synchronised pin level
  input wire [1:0] detMode, // selected condition
  input wire xferMode, // channel feeds the automatic transfer
  output reg hit // condition seen this cycle
);

  reg prev_r; // pin level one cycle back, for edges

  // previous level resets high so a high pin at release is no rising edge
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= pinLevel;
    end
  end

  // edge codes are refused in transfer mode: a transfer wants a held level
  always @* begin
    hit = 1'b0;
    case (detMode)
      `DET_LOW: hit = ~pinLevel;
      `DET_HIGH: hit = pinLevel;
      `DET_RISE: hit = ~xferMode & pinLevel & ~prev_r;
      `DET_FALL: hit = ~xferMode & ~pinLevel & prev_r;
      default: hit = 1'b0;
    endcase
  end

endmodule // ext_channel_detect

// ===== test/xfer_partner.sv
`timescale 1ns/100ps
// far side of the transfer link: finishes each owed transfer after a set lag
module xfer_partner (
  input wire mclk, // clock
  input wire rst_n, // reset
  input wire pinTransferRequest, // transfer owed
  input wire [3:0] lag, // wait before finishing
  output logic transferDone // one-cycle finish pulse
);
  logic [3:0] cnt_r; // cycles spent on this transfer
  // a withdrawn request is an abort, so the count restarts rather than finishing late
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      transferDone <= 1'b0;
    end else if (transferDone || !pinTransferRequest) begin
      cnt_r <= 4'h0;
      transferDone <= 1'b0;
    end else if (cnt_r == lag) begin
      transferDone <= 1'b1; // finish pulse
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // xfer_partner

// ===== test/ews_checker.sv
`timescale 1ns/100ps
// port watcher for bus, wake and transfer ordering
module ews_checker (
  input wire mclk, // clock
  input wire rst_n, // reset
  input wire wbCyc, // cycle
  input wire wbStb, // strobe
  input wire wbWe, // write
  input wire [7:0] wbAdr, // address
  input wire [3:0] wbSel, // selects
  input wire [31:0] wbDatIn, // write data
  input wire wbAck, // ack
  input wire hwStandbyPin_n, // hw standby
  input wire swStandby, // sw standby
  input wire [7:0] extIrq, // handler reqs
  input wire pinTransferRequest, // transfer owed
  input wire [2:0] pinTransferChan, // its channel
  input wire transferDone, // finished
  input wire wakeIrq, // wake irq
  input wire wakeupReq, // standby exit
  input wire delayedIrq // task switch
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // accepted write to the delayed request word
  wire dlyWr = wbCyc & wbStb & wbWe & wbAck & wbSel[0] & (wbAdr[7:2] == 6'h06);
  logic [1:0] dlyHist_r; // recent such writes
  // the output may trail the write by a stage, so two cycles excuse a change
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dlyHist_r <= 2'h0;
    end else begin
      dlyHist_r <= {dlyHist_r[0], dlyWr};
    end
  end
  property p_ack; wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck; endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_dly_set; dlyWr && wbDatIn[0] |-> ##[1:2] delayedIrq; endproperty
  a_dly_set: assert property (p_dly_set) else $error("delayed set lost");
  property p_dly_clr; dlyWr && !wbDatIn[0] |-> ##[1:2] !delayedIrq; endproperty
  a_dly_clr: assert property (p_dly_clr) else $error("delayed clear lost");
  property p_dly_only; $changed(delayedIrq) |-> dlyHist_r != 2'h0; endproperty
  a_dly_only: assert property (p_dly_only) else $error("delayed moved alone");
  property p_wake_sw; wakeupReq |-> (wakeIrq || $past(wakeIrq)) && $past(swStandby); endproperty
  a_wake_sw: assert property (p_wake_sw) else $error("exit without wake");
  property p_wake_hw; (!hwStandbyPin_n) [*5] |-> !wakeupReq; endproperty
  a_wake_hw: assert property (p_wake_hw) else $error("exit from hw standby");
  property p_xfer_first; pinTransferRequest |-> !extIrq[pinTransferChan]; endproperty
  a_xfer_first: assert property (p_xfer_first) else $error("handler early");
  property p_xfer_done;
    transferDone && pinTransferRequest |-> ##2 extIrq[$past(pinTransferChan, 2)];
  endproperty
  a_xfer_done: assert property (p_xfer_done) else $error("handler missing");
  cover property (dlyWr);
  cover property (transferDone && pinTransferRequest);
  cover property (wakeupReq);
endmodule // ews_checker

bind external_wakeup_soft_interrupts ews_checker i_ews_checker (.mclk, .rst_n, .wbCyc, .wbStb,
  .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbAck, .hwStandbyPin_n, .swStandby, .extIrq,
  .pinTransferRequest, .pinTransferChan, .transferDone, .wakeIrq, .wakeupReq, .delayedIrq);

// ===== test/external_wakeup_soft_interrupts_test.sv
`timescale 1ns/100ps
// self-checking bench: random pin patterns, bus traffic, quick and slow transfers
module external_wakeup_soft_interrupts_test;
  logic mclk = 1'b0; // clock
  logic rst_n = 1'b0; // reset
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0; // bus controls
  logic [7:0] wbAdr = 8'h00; // address
  logic [3:0] wbSel = 4'h0; // selects
  logic [31:0] wbDatIn = 32'h0, wbDatOut, q; // bus data, last read
  logic wbAck, pinTransferRequest, transferDone, wakeIrq, wakeupReq, delayedIrq; // outputs
  logic [7:0] extRequestPins = 8'hff; // idle high keeps low detection quiet
  logic [7:0] wakePins_n = 8'hff; // released
  logic hwStandbyPin_n = 1'b1, swStandby = 1'b0; // standby inputs
  logic [7:0] extIrq, pat, en, idle; // outputs and stimulus
  logic [2:0] pinTransferChan, ch; // channel
  logic [1:0] md; // detection code
  logic [3:0] lag = 4'h0; // service latency
  logic [31:0] seed = 32'h3bcc2923; // xorshift state
  int n_mismatch = 0, samples_checked = 0; // counters

  always #5 mclk = ~mclk;

  external_wakeup_soft_interrupts i_external_wakeup_soft_interrupts (.mclk, .rst_n, .wbCyc,
    .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck, .extRequestPins, .wakePins_n,
    .hwStandbyPin_n, .swStandby, .extIrq, .pinTransferRequest, .pinTransferChan,
    .transferDone, .wakeIrq, .wakeupReq, .delayedIrq);
  xfer_partner i_xfer_partner (.mclk, .rst_n, .pinTransferRequest, .lag, .transferDone);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // pin level at which the given code sees nothing
  function automatic logic [7:0] idleOf(input logic [1:0] m);
    return (m == 2'h0 || m == 2'h3) ? 8'hff : 8'h00;
  endfunction

  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // a bounded wait that ran out ends the run as a failure
  task automatic guard(input int n);
    if (n >= 60) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  // one classic cycle; no latency assumed, the ack edge or the 60 cycle limit ends it
  task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn} <= {2'h3, we, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 60);
    q = wbDatOut;
    {wbCyc, wbStb} <= 2'h0;
    guard(n);
  endtask

  task automatic rdk(input logic [7:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask

  // waits for the transfer request (0) or the finish pulse (1)
  task automatic wt(input bit done);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((done ? transferDone : pinTransferRequest) !== 1'b1 && n < 60);
    guard(n);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    wbx(1'b1, 8'h20, xs()); // unmapped write must change nothing
    for (int a = 0; a < 32'h24; a += 4) rdk(a[7:0], 32'h0);
    for (int v = 1; v >= 0; v--) begin
      wbx(1'b1, 8'h18, (xs() & 32'hfffffffe) | 32'(v));
      rdk(8'h18, 32'(v));
      chk("delayedIrq", 32'(v), delayedIrq);
    end
    // every code twice; pat marks the channels whose pin leaves idle
    for (int m = 0; m < 8; m++) begin
      md = m[1:0];
      idle = idleOf(md);
      pat = xs();
      en = xs();
      extRequestPins <= idle;
      wbx(1'b1, 8'h00, {16'h0, {8{md}}});
      wbx(1'b1, 8'h04, {24'h0, en});
      wbx(1'b1, 8'h0c, 32'h0);
      tick(6);
      wbx(1'b1, 8'h08, 32'h0);
      extRequestPins <= idle ^ pat;
      tick(6);
      rdk(8'h08, {24'h0, pat});
      chk("extIrq", {24'h0, pat & en}, extIrq);
      extRequestPins <= idle;
      tick(6);
      rdk(8'h08, {24'h0, pat});
      wbx(1'b1, 8'h08, 32'h0);
      rdk(8'h08, 32'h0);
    end
    // transfer before handler, service lag drawn at random
    repeat (3) begin
      ch = xs();
      lag <= xs();
      extRequestPins <= 8'h00;
      wbx(1'b1, 8'h00, 32'h5555);
      wbx(1'b1, 8'h04, 32'h1 << ch);
      // stale edge flags go before the channel turns into a transfer channel
      wbx(1'b1, 8'h08, 32'h0);
      wbx(1'b1, 8'h0c, 32'h1 << ch);
      extRequestPins <= 8'h01 << ch;
      wt(1'b0);
      chk("pinTransferChan", 32'(ch), pinTransferChan);
      chk("extIrq", 32'h0, extIrq);
      wt(1'b1);
      tick(3);
      chk("extIrq", 32'h1 << ch, extIrq);
      extRequestPins <= 8'h00;
      wbx(1'b1, 8'h08, 32'h0);
    end
    wbx(1'b1, 8'h00, 32'haaaa); // rising edge on a transfer channel
    extRequestPins <= 8'h01 << ch;
    tick(6);
    rdk(8'h08, 32'h0);
    chk("pinTransferRequest", 32'h0, pinTransferRequest);
    wbx(1'b1, 8'h10, 32'h1ff);
    ch = xs();
    wakePins_n <= ~(8'h01 << ch);
    tick(4);
    wakePins_n <= 8'hff;
    rdk(8'h14, 32'h1);
    chk("wakeIrq", 32'h1, wakeIrq);
    swStandby <= 1'b1;
    tick(3);
    chk("wakeupReq", 32'h1, wakeupReq);
    hwStandbyPin_n <= 1'b0;
    tick(6);
    chk("wakeupReq", 32'h0, wakeupReq);
    {hwStandbyPin_n, swStandby} <= 2'h2;
    wbx(1'b1, 8'h10, 32'h0ff);
    tick(3);
    chk("wakeIrq", 32'h0, wakeIrq);
    wbx(1'b1, 8'h14, 32'h0);
    rdk(8'h14, 32'h0);
    report_and_stop();
  end
endmodule // external_wakeup_soft_interrupts_test
